// ===== core/ssc_pkg.sv
// Purpose: Shared constants and types for the scale setup and serial block
// Assumes: 10 MHz pclk, APB slave with 32-bit data
// Notes:   Step values are small codes; see step_min and step_max
`default_nettype none
package ssc_pkg;
  localparam int unsigned CLK_HZ     = 10_000_000;
  localparam int unsigned BAUD_HZ    = 9600;
  localparam int unsigned BIT_CYC    = (CLK_HZ + BAUD_HZ / 2) / BAUD_HZ;
  localparam int unsigned DATA_BITS  = 7;
  localparam int unsigned STOP_BITS  = 2;
  localparam int unsigned FRAME_BITS = DATA_BITS + STOP_BITS + 2;
  localparam int unsigned NSTEPS     = 21;
  localparam int unsigned VAL_W      = 5;
  localparam int unsigned INIT_WAIT  = 3;

  localparam logic [6:0] CH_CLEAR = 7'h43;
  localparam logic [6:0] CH_TARE  = 7'h54;
  localparam logic [6:0] CH_PRINT = 7'h50;
  localparam logic [6:0] CH_ZERO  = 7'h5A;

  localparam logic [7:0] OFF_STATUS = 8'h00;
  localparam logic [7:0] OFF_TXDATA = 8'h04;
  localparam logic [7:0] OFF_INDEX  = 8'h08;
  localparam logic [7:0] OFF_VALUE  = 8'h0C;

  localparam logic [4:0] STP_GEO     = 5'h01;
  localparam logic [4:0] STP_LOCKOUT = 5'h04;
  localparam logic [1:0] BLK_SCALE   = 2'h0;
  localparam logic [1:0] BLK_LAST    = 2'h2;
  localparam logic [1:0] CH_SAVE     = 2'h0;
  localparam logic [1:0] CH_ABORT    = 2'h1;
  localparam logic [1:0] CH_DEFAULT  = 2'h2;

  typedef enum logic [1:0] {ST_RUN, ST_BLOCK, ST_STEP, ST_SAVE} ssc_state_t;
  typedef struct packed {logic prn; logic zro; logic fnc;} ssc_key_t;
  typedef struct packed {
    logic clear_tare; logic tare; logic print; logic zero;
  } ssc_cmd_t;
  typedef struct packed {
    logic             in_setup;
    logic             view_only;
    logic [1:0]       block;
    logic [4:0]       step;
    logic [VAL_W-1:0] value;
    logic [1:0]       choice;
  } ssc_disp_t;

  // Factory table; ctry0 selects the country code 000 variant
  function automatic logic [VAL_W-1:0] factory_value(
      input logic [4:0] idx, input logic ctry0);
    case (idx)
      5'h00: factory_value = ctry0 ? 5'h01 : 5'h02;
      5'h01: factory_value = 5'h0C;
      5'h04, 5'h05, 5'h06:
             factory_value = ctry0 ? ((idx == 5'h05) ? 5'h02 : 5'h01) : 5'h00;
      5'h07, 5'h0A, 5'h13: factory_value = 5'h01;
      5'h08, 5'h09, 5'h0D: factory_value = ctry0 ? 5'h02 : 5'h01;
      5'h0E: factory_value = 5'h04;
      5'h0F: factory_value = 5'h07;
      5'h10, 5'h11, 5'h12: factory_value = 5'h02;
      default: factory_value = 5'h00;
    endcase
  endfunction

  function automatic logic [VAL_W-1:0] step_min(input logic [4:0] idx);
    case (idx)
      5'h00, 5'h10: step_min = 5'h01;
      5'h0F:        step_min = 5'h07;
      default:      step_min = 5'h00;
    endcase
  endfunction

  function automatic logic [VAL_W-1:0] step_max(input logic [4:0] idx);
    case (idx)
      5'h00: step_max = 5'h03;
      5'h01: step_max = 5'h1F;
      5'h05, 5'h08, 5'h09, 5'h0D, 5'h10, 5'h11, 5'h12: step_max = 5'h02;
      5'h0A, 5'h0B: step_max = 5'h03;
      5'h0E: step_max = 5'h06;
      5'h0F: step_max = 5'h08;
      default: step_max = 5'h01;
    endcase
  endfunction

  function automatic logic [4:0] blk_first(input logic [1:0] b);
    blk_first = (b == 2'h0) ? 5'h00 : ((b == 2'h1) ? 5'h05 : 5'h0E);
  endfunction

  function automatic logic [4:0] blk_end(input logic [1:0] b);
    blk_end = (b == 2'h0) ? 5'h04 : ((b == 2'h1) ? 5'h0D : 5'h14);
  endfunction
endpackage
`default_nettype wire

// ===== core/ssc_top.sv
// Purpose: Serial command decoder, keypad setup menu and retained settings
// Assumes: Keys, jumper, strap and rxd are asynchronous and active high
// Notes:   Serial framing is fixed at the factory framing
//
// Chosen here: the APB register port and the address map.
`default_nettype none
module ssc_top #(
  parameter int unsigned BIT_CYCLES = ssc_pkg::BIT_CYC
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [7:0]       paddr,
  input  wire logic [31:0]      pwdata,
  output logic      [31:0]      prdata,
  output logic                  pready,
  output logic                  pslverr,
  input  wire logic             rxd,
  output logic                  txd,
  input  wire ssc_pkg::ssc_key_t keys,
  input  wire logic             access_jumper,
  input  wire logic             country_zero,
  output ssc_pkg::ssc_cmd_t     cmd,
  output ssc_pkg::ssc_disp_t    disp,
  output logic      [1:0]       zero_range
);
  import ssc_pkg::*;
  localparam int unsigned CW = $clog2(BIT_CYCLES + 1);
  localparam logic [CW-1:0] BIT_END  = CW'(BIT_CYCLES - 1);
  localparam logic [CW-1:0] HALF_END = CW'(BIT_CYCLES / 2 - 1);
  localparam logic [3:0]    RX_LAST  = 4'(FRAME_BITS - 2);
  localparam logic [3:0]    TX_LAST  = 4'(FRAME_BITS - 1);
  // Pin synchronisers; idle reset levels avoid a false key release
  logic [5:0] meta_reg;
  logic [5:0] sync_reg;
  logic [2:0] key_prev_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_reg     <= 6'h20;
      sync_reg     <= 6'h20;
      key_prev_reg <= 3'h0;
    end else begin
      meta_reg     <= {rxd, keys, access_jumper, country_zero};
      sync_reg     <= meta_reg;
      key_prev_reg <= sync_reg[4:2];
    end
  end
  wire       rx_s  = sync_reg[5];
  wire [2:0] key_s = sync_reg[4:2];
  wire       jmp_s = sync_reg[1];
  wire       ctry0 = sync_reg[0];
  // Key actions happen on release so a held key acts once
  wire rel_prn = key_prev_reg[2] & ~key_s[2];
  wire rel_zro = key_prev_reg[1] & ~key_s[1];
  wire rel_fnc = key_prev_reg[0] & ~key_s[0];
  // Serial receiver
  logic          rx_busy_reg;
  logic [CW-1:0] rx_cnt_reg;
  logic [3:0]    rx_bit_reg;
  logic [9:0]    rx_sh_reg;
  logic          rx_done_reg;
  logic [6:0]    rx_char_reg;
  wire rx_tick  = rx_busy_reg && (rx_cnt_reg == ((rx_bit_reg == 4'h0) ?
                  HALF_END : BIT_END));
  wire rx_final = rx_tick && (rx_bit_reg == RX_LAST);
  // Frame: start, 7 data, parity, first stop; second stop is idle time
  wire [9:0] rx_frame = {rx_s, rx_sh_reg[9:1]};
  wire rx_good = rx_frame[9] && !rx_frame[0] &&
                 ~^rx_frame[8:1];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_busy_reg <= 1'b0;
      rx_cnt_reg  <= '0;
      rx_bit_reg  <= 4'h0;
      rx_sh_reg   <= 10'h000;
      rx_done_reg <= 1'b0;
      rx_char_reg <= 7'h00;
    end else begin
      rx_done_reg <= rx_final && rx_good;
      if (!rx_busy_reg) begin
        rx_busy_reg <= !rx_s;
        rx_cnt_reg  <= '0;
        rx_bit_reg  <= 4'h0;
      end else if (rx_tick) begin
        rx_cnt_reg <= '0;
        rx_sh_reg  <= rx_frame;
        rx_bit_reg <= rx_bit_reg + 4'h1;
        if (rx_final) begin
          rx_busy_reg <= 1'b0;
          if (rx_good) begin
            rx_char_reg <= rx_frame[7:1];
          end
        end
      end else begin
        rx_cnt_reg <= rx_cnt_reg + CW'(1);
      end
    end
  end
  // Commands; anything else falls through with no effect
  wire [6:0] rc = rx_char_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd <= '0;
    end else begin
      cmd.clear_tare <= rx_done_reg && (rc == CH_CLEAR);
      cmd.tare       <= rx_done_reg && (rc == CH_TARE);
      cmd.print      <= rx_done_reg && (rc == CH_PRINT);
      cmd.zero       <= rx_done_reg && (rc == CH_ZERO);
    end
  end
  // Transmitter fed by the TX data register
  logic [10:0]   tx_sh_reg;
  logic [3:0]    tx_bit_reg;
  logic [CW-1:0] tx_cnt_reg;
  logic          tx_busy_reg;
  wire apb_wr = psel && penable && pready && pwrite;
  wire tx_go  = apb_wr && (paddr == OFF_TXDATA) && !tx_busy_reg;
  wire [6:0] tx_d = pwdata[6:0];
  wire tx_tick = tx_busy_reg && (tx_cnt_reg == BIT_END);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_sh_reg   <= 11'h7FF;
      tx_bit_reg  <= 4'h0;
      tx_cnt_reg  <= '0;
      tx_busy_reg <= 1'b0;
      txd         <= 1'b1;
    end else if (tx_go) begin
      tx_sh_reg   <= {2'b11, ^tx_d, tx_d, 1'b0};
      tx_bit_reg  <= 4'h0;
      tx_cnt_reg  <= '0;
      tx_busy_reg <= 1'b1;
    end else if (tx_tick) begin
      tx_cnt_reg  <= '0;
      tx_bit_reg  <= tx_bit_reg + 4'h1;
      tx_sh_reg   <= {1'b1, tx_sh_reg[10:1]};
      tx_busy_reg <= (tx_bit_reg != TX_LAST);
    end else if (tx_busy_reg) begin
      tx_cnt_reg <= tx_cnt_reg + CW'(1);
      txd        <= tx_sh_reg[0];
    end else begin
      txd <= 1'b1;
    end
  end
  // Setup menu
  ssc_state_t       st_reg;
  logic [1:0]       blk_reg;
  logic [4:0]       stp_reg;
  logic [1:0]       choice_reg;
  logic             combo_reg;
  logic             view_reg;
  logic [1:0]       init_reg;
  logic [VAL_W-1:0] cfg_reg  [NSTEPS];
  logic [VAL_W-1:0] edit_reg [NSTEPS];
  wire lock_open  = cfg_reg[STP_LOCKOUT] == 5'h01;
  wire may_enter  = jmp_s || lock_open;
  wire enter      = (st_reg == ST_RUN) && combo_reg && !key_s[2] &&
                    !key_s[1] && may_enter;
  wire [VAL_W-1:0] cur_val = edit_reg[stp_reg];
  wire [VAL_W-1:0] nxt_val = (cur_val >= step_max(stp_reg)) ?
                             step_min(stp_reg) : cur_val + 5'h01;
  wire bump = (st_reg == ST_STEP) && rel_fnc &&
              !(view_reg && blk_reg == BLK_SCALE);
  wire apply = (st_reg == ST_SAVE) && rel_prn;
  wire load_fac = init_reg == 2'(INIT_WAIT - 1);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      init_reg  <= 2'h0;
      combo_reg <= 1'b0;
    end else begin
      if (init_reg != 2'(INIT_WAIT)) begin
        init_reg <= init_reg + 2'h1;
      end
      if (st_reg != ST_RUN || (!key_s[2] && !key_s[1])) begin
        combo_reg <= 1'b0;
      end else if (key_s[2] && key_s[1]) begin
        combo_reg <= 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg     <= ST_RUN;
      blk_reg    <= 2'h0;
      stp_reg    <= 5'h00;
      choice_reg <= CH_SAVE;
      view_reg   <= 1'b0;
    end else begin
      unique case (st_reg)
        ST_RUN: if (enter) begin
          st_reg   <= ST_BLOCK;
          blk_reg  <= 2'h0;
          view_reg <= !jmp_s;
        end
        ST_BLOCK: if (rel_prn) begin
          st_reg  <= ST_STEP;
          stp_reg <= blk_first(blk_reg);
        end else if (rel_fnc) begin
          if (blk_reg == BLK_LAST) begin
            st_reg     <= ST_SAVE;
            choice_reg <= CH_SAVE;
          end else begin
            blk_reg <= blk_reg + 2'h1;
          end
        end else if (rel_zro && blk_reg != 2'h0) begin
          blk_reg <= blk_reg - 2'h1;
        end
        ST_STEP: if (rel_prn) begin
          if (stp_reg != blk_end(blk_reg)) begin
            stp_reg <= stp_reg + 5'h01;
          end else if (blk_reg == BLK_LAST) begin
            st_reg     <= ST_SAVE;
            choice_reg <= CH_SAVE;
          end else begin
            st_reg  <= ST_BLOCK;
            blk_reg <= blk_reg + 2'h1;
          end
        end
        ST_SAVE: if (rel_prn) begin
          st_reg <= ST_RUN;
        end else if (rel_fnc) begin
          choice_reg <= (choice_reg == CH_DEFAULT) ? CH_SAVE :
                        choice_reg + 2'h1;
        end
      endcase
    end
  end
  // Retained and session copies, one entry per step
  for (genvar i = 0; i < NSTEPS; i++) begin : g_step
    localparam logic [4:0] IDX = 5'(i);
    // Calibration units and gravity are not reset by a default
    localparam bit KEEP = (i == 0) || (IDX == STP_GEO);
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        cfg_reg[i] <= factory_value(IDX, 1'b0);
      end else if (load_fac) begin
        cfg_reg[i] <= factory_value(IDX, ctry0);
      end else if (apply && choice_reg == CH_SAVE) begin
        cfg_reg[i] <= edit_reg[i];
      end else if (apply && choice_reg == CH_DEFAULT && !KEEP) begin
        cfg_reg[i] <= factory_value(IDX, ctry0);
      end
    end
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        edit_reg[i] <= '0;
      end else if (enter) begin
        edit_reg[i] <= cfg_reg[i];
      end else if (bump && stp_reg == IDX) begin
        edit_reg[i] <= nxt_val;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      disp       <= '0;
      zero_range <= 2'h1;
    end else begin
      disp.in_setup  <= st_reg != ST_RUN;
      disp.view_only <= view_reg && st_reg != ST_RUN;
      disp.block     <= blk_reg;
      disp.step      <= stp_reg;
      disp.value     <= (st_reg == ST_STEP) ? cur_val : '0;
      disp.choice    <= choice_reg;
      zero_range     <= cfg_reg[5'h08][1:0];
    end
  end
  // APB slave: answer one cycle after setup, no wait states
  logic [4:0] index_reg;
  wire apb_setup = psel && !penable;
  wire hit = (paddr == OFF_STATUS) || (paddr == OFF_TXDATA) ||
             (paddr == OFF_INDEX) || (paddr == OFF_VALUE);
  wire [4:0] idx_clip = (index_reg < 5'(NSTEPS)) ? index_reg : 5'h00;
  wire [31:0] rd_mux =
    (paddr == OFF_STATUS) ? {24'h0, jmp_s, st_reg, rx_char_reg[4:0]
                             == 5'h00, 1'b0, tx_busy_reg, rx_busy_reg,
                             disp.in_setup} :
    (paddr == OFF_TXDATA) ? {24'h0, 1'b0, rx_char_reg} :
    (paddr == OFF_INDEX)  ? {27'h0, index_reg} :
    (paddr == OFF_VALUE)  ? {27'h0, cfg_reg[idx_clip]} : 32'h0;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready    <= 1'b0;
      pslverr   <= 1'b0;
      prdata    <= 32'h0;
      index_reg <= 5'h00;
    end else begin
      pready  <= apb_setup;
      pslverr <= apb_setup && !hit;
      prdata  <= (apb_setup && !pwrite) ? rd_mux : 32'h0;
      if (apb_wr && paddr == OFF_INDEX) begin
        index_reg <= pwdata[4:0];
      end
    end
  end

  sequence s_combo;
    key_s[2] && key_s[1] && st_reg == ST_RUN;
  endsequence
  sequence s_release;
    !key_s[2] && !key_s[1] && may_enter;
  endsequence
  property p_enter;
    @(posedge pclk) disable iff (!presetn)
    s_combo ##1 s_release |=> st_reg == ST_BLOCK;
  endproperty
  AST_ENTER: assert property (p_enter)
    else $error("Combo release did not enter setup");
  AST_LOCKED: assert property (@(posedge pclk) disable iff (!presetn)
    (st_reg == ST_RUN && !jmp_s && !lock_open) |=> st_reg == ST_RUN)
    else $error("Setup entered while locked");
  AST_CMD_Z: assert property (@(posedge pclk) disable iff (!presetn)
    rx_done_reg && rc == CH_ZERO |=> cmd.zero ##1 !cmd.zero)
    else $error("Zero command not one pulse");
  AST_IGNORE: assert property (@(posedge pclk) disable iff (!presetn)
    rx_done_reg && rc != CH_CLEAR && rc != CH_TARE && rc != CH_PRINT &&
    rc != CH_ZERO |=> cmd == '0)
    else $error("Unknown character acted on");
  AST_NEXT_BLK: assert property (@(posedge pclk) disable iff (!presetn)
    st_reg == ST_BLOCK && !rel_prn && rel_fnc && blk_reg != BLK_LAST
    |=> blk_reg == $past(blk_reg) + 2'h1)
    else $error("Function did not advance block");
  AST_SAVE: assert property (@(posedge pclk) disable iff (!presetn)
    apply && choice_reg == CH_SAVE && !load_fac
    |=> cfg_reg[STP_LOCKOUT] == $past(edit_reg[STP_LOCKOUT])
        && st_reg == ST_RUN)
    else $error("Save did not store edits");
  AST_ABORT: assert property (@(posedge pclk) disable iff (!presetn)
    apply && choice_reg == CH_ABORT && !load_fac
    |=> $stable(cfg_reg[5'h07]))
    else $error("Abort changed settings");
  AST_KEEP_GEO: assert property (@(posedge pclk) disable iff (!presetn)
    apply && choice_reg == CH_DEFAULT && !load_fac
    |=> $stable(cfg_reg[STP_GEO]) && cfg_reg[5'h10] == 5'h02)
    else $error("Default touched gravity or missed stop bits");
  AST_TX_FRAME: assert property (@(posedge pclk) disable iff (!presetn)
    tx_go |=> tx_busy_reg [*8])
    else $error("Transmit frame ended early");
endmodule
`default_nettype wire

// ===== test/ssc_host.sv
// Purpose: Serial partner that sends command characters and reads output
// Assumes: Seven data bits, even parity, two stop bits, LSB first
// Notes:   Line rests high between frames, as an RS-232 mark
`default_nettype none
module ssc_host #(
  parameter int unsigned BIT_CYCLES = 16
) (
  input  wire logic pclk,
  output logic      rxd,
  input  wire logic txd
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [6:0] got_char;
  logic       got_ok;
  int         got_cnt;
  logic [9:0] fr;

  initial begin
    rxd = 1'b1;
    got_char = 7'h00;
    got_ok = 1'b0;
    got_cnt = 0;
  end

  // Start, data, parity, then two stops; each bit lasts BIT_CYCLES edges
  task automatic send(input logic [6:0] ch);
    logic [10:0] f;
    f = {2'b11, ^ch, ch, 1'b0};
    for (int i = 0; i < 11; i++) begin
      @(posedge pclk);
      rxd <= f[i];
      repeat (BIT_CYCLES - 1) @(posedge pclk);
    end
  endtask

  // Samples mid-bit so a one-cycle lag on txd does not matter
  always begin
    @(negedge txd);
    repeat (BIT_CYCLES / 2) @(posedge pclk);
    for (int i = 0; i < 10; i++) begin
      repeat (BIT_CYCLES) @(posedge pclk);
      fr[i] = txd;
    end
    got_char = fr[6:0];
    got_ok = (fr[7] == ^fr[6:0]) && fr[8] && fr[9];
    got_cnt++;
  end
endmodule
`default_nettype wire

// ===== test/ssc_top_tb.sv
// Purpose: Self-checking bench for the scale setup and serial block
// Assumes: Shortened bit period; host model on the serial pins
// Notes:   Factory and command rows run in loops, menu cases by hand
`default_nettype none
module ssc_top_tb;
  import ssc_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int unsigned BITC = 16;
  logic        pclk, presetn, psel, penable, pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, rxd, txd, jmp, ctry, err;
  ssc_key_t    keys;
  ssc_cmd_t    cmd, seen;
  ssc_disp_t   disp;
  logic [1:0]  zero_range;
  int          fails, cmp_count, cyc, n;
  // Rows: {step index, factory value}
  logic [15:0] frow [19] = '{16'h010C, 16'h0200, 16'h0300, 16'h0400,
    16'h0500, 16'h0600, 16'h0701, 16'h0801, 16'h0901, 16'h0A01, 16'h0B00,
    16'h0C00, 16'h0D01, 16'h0F07, 16'h1002, 16'h1102, 16'h1202, 16'h1301,
    16'h1400};
  // Rows: {received character, expected command pulse}
  logic [15:0] crow [6] = '{16'h4308, 16'h5404, 16'h5002, 16'h5A01,
    16'h4100, 16'h6300};

  ssc_top #(.BIT_CYCLES(BITC)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rxd(rxd), .txd(txd),
    .keys(keys), .access_jumper(jmp), .country_zero(ctry), .cmd(cmd),
    .disp(disp), .zero_range(zero_range));
  ssc_host #(.BIT_CYCLES(BITC)) host (.pclk(pclk), .rxd(rxd), .txd(txd));

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  // Pulses last one cycle, so they are latched for the loop to compare
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cmd !== 4'h0) seen <= cmd;
    if (cyc == 20000) begin
      fails++;
      finish_test();
    end
  end

  task automatic chk(input string nm, input logic [31:0] ex, got);
    cmp_count++;
    if (got !== ex) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, ex, got);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdset(input logic [4:0] i);
    apb(1'b1, OFF_INDEX, {27'h0, i});
    apb(1'b0, OFF_VALUE, 32'h0);
  endtask

  // Held long enough to clear the key synchroniser before release
  task automatic press(input logic [2:0] k);
    @(posedge pclk);
    keys <= k;
    repeat (6) @(posedge pclk);
    keys <= 3'h0;
    repeat (8) @(posedge pclk);
  endtask

  task automatic session(input int ed, input int pk, input int ev);
    press(3'b110);
    press(3'b001);
    press(3'b100);
    chk("step", 5, disp.step);
    repeat (ed) press(3'b001);
    chk("value", ev, disp.value);
    repeat (9) press(3'b100);
    press(3'b001);
    repeat (pk) press(3'b001);
    chk("choice", pk, disp.choice);
    press(3'b100);
    chk("in setup", 0, disp.in_setup);
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    keys = 3'h0;
    jmp = 1'b1;
    ctry = 1'b0;
    seen = 4'h0;
    fails = 0;
    cmp_count = 0;
    cyc = 0;
    repeat (3) @(posedge pclk);
    chk("txd idle", 1, txd);
    presetn <= 1'b1;
    repeat (5) @(posedge pclk);
    chk("zero range", 1, zero_range);
    $display("test reset done");
    foreach (frow[i]) begin
      rdset(frow[i][12:8]);
      chk("factory", frow[i][4:0], rd);
    end
    $display("test factory done");
    foreach (crow[i]) begin
      seen <= 4'h0;
      host.send(crow[i][14:8]);
      repeat (4) @(posedge pclk);
      chk("cmd", crow[i][3:0], seen);
    end
    apb(1'b0, OFF_TXDATA, 32'h0);
    chk("rx char", 32'h63, rd);
    $display("test commands done");
    n = host.got_cnt;
    apb(1'b1, OFF_TXDATA, 32'h43);
    apb(1'b0, OFF_STATUS, 32'h0);
    chk("status", 32'h84, rd);
    for (int t = 0; t < 400 && host.got_cnt == n; t++) @(posedge pclk);
    chk("tx char", 32'h43, host.got_char);
    chk("tx frame", 1, host.got_ok);
    apb(1'b0, 8'h10, 32'h0);
    chk("slverr", 1, err);
    chk("rdata", 0, rd);
    $display("test tx done");
    press(3'b110);
    chk("in setup", 1, disp.in_setup);
    chk("block", 0, disp.block);
    press(3'b001);
    chk("block", 1, disp.block);
    press(3'b010);
    chk("block", 0, disp.block);
    press(3'b001);
    press(3'b001);
    press(3'b001);
    chk("choice", CH_SAVE, disp.choice);
    press(3'b001);
    chk("choice", CH_ABORT, disp.choice);
    press(3'b100);
    chk("in setup", 0, disp.in_setup);
    $display("test navigation done");
    session(1, 0, 1);
    rdset(5'h05);
    chk("saved", 1, rd);
    session(1, 1, 2);
    rdset(5'h05);
    chk("aborted", 1, rd);
    session(0, 2, 1);
    rdset(5'h05);
    chk("default", 0, rd);
    rdset(5'h01);
    chk("gravity", 12, rd);
    $display("test save done");
    jmp <= 1'b0;
    press(3'b110);
    chk("locked", 0, disp.in_setup);
    $display("test lockout done");
    ctry <= 1'b1;
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    repeat (5) @(posedge pclk);
    rdset(5'h00);
    chk("cal units", 1, rd);
    rdset(5'h04);
    chk("lockout", 1, rd);
    rdset(5'h05);
    chk("alt units", 2, rd);
    chk("zero range", 2, zero_range);
    $display("test country done");
    press(3'b110);
    chk("view only", 1, disp.view_only);
    press(3'b100);
    press(3'b001);
    chk("view value", 1, disp.value);
    $display("test view only done");
    finish_test();
  end
endmodule
`default_nettype wire
